// ### core/lbs_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "lbs_params.svh"
module lbs_decode
(
    lbs_if.dec d
);
    // pure decode of the fetched word
    always_comb
    begin
        d.op = lbs_pkg::LBS_NONE;
        d.dest = d.instr[`LBS_OP_DEST_BIT];
        d.bidx = d.instr[`LBS_OP_BIDX_MSB:`LBS_OP_BIDX_LSB];
        if (d.instr[`LBS_OP_AND_HI_MSB:`LBS_OP_AND_HI_LSB] == `LBS_OP_AND_HI)
            d.op = lbs_pkg::LBS_AND;
        else if (d.instr[`LBS_OP_BCLR_HI_MSB:`LBS_OP_BCLR_HI_LSB]
                 == `LBS_OP_BCLR_HI)
            d.op = lbs_pkg::LBS_BCLR;
        else if (d.instr[15:8] == `LBS_OP_CSEQ)
            d.op = lbs_pkg::LBS_CSEQ;
        else if (d.instr[15:8] == `LBS_OP_CSGT)
            d.op = lbs_pkg::LBS_CSGT;
    end
endmodule // lbs_decode
`default_nettype wire

// ### core/lbs_exec.sv
`timescale 1ns/1ns
`default_nettype none
`include "lbs_params.svh"
module lbs_exec
(
    // clock, reset, enable
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic CLK_EN_IN,
    // instruction issue, one per enabled cycle
    input wire logic INSTR_VALID_IN,
    input wire logic [15:0] INSTR_IN,
    input wire logic [7:0] BYTE_IN,
    // accumulator load
    input wire logic ACC_LOAD_IN,
    input wire logic [7:0] ACC_LOAD_DATA_IN,
    // results
    output logic [7:0] ACC_OUT,
    output logic [7:0] STATUS_OUT,
    output logic BYTE_WE_OUT,
    output logic [7:0] BYTE_WDATA_OUT,
    output logic SKIP_OUT,
    output logic NOP_EXEC_OUT
);
    lbs_if dif();
    lbs_decode u_dec (.d(dif));
    assign dif.instr = INSTR_IN;

    logic [7:0] acc;
    logic [7:0] stat;
    logic skip_pend;
    logic act;
    logic [7:0] and_res;
    logic [8:0] diff;

    // unsigned byte minus acc, borrow in bit 8
    function automatic logic [8:0] sub_u(input logic [7:0] a,
                                         input logic [7:0] b);
        sub_u = {1'b0, a} - {1'b0, b};
    endfunction

    // a skipped slot executes as nop whatever was fetched
    assign act = CLK_EN_IN && INSTR_VALID_IN && !skip_pend;
    assign and_res = acc & BYTE_IN;
    assign diff = sub_u(BYTE_IN, acc);

    // accumulator: load port or AND result
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            acc <= `LBS_ACC_RST;
        else if (CLK_EN_IN)
        begin
            if (act && dif.op == lbs_pkg::LBS_AND && !dif.dest)
                acc <= and_res;
            else if (ACC_LOAD_IN)
                acc <= ACC_LOAD_DATA_IN;
        end
    end

    // status: only the zero bit moves, only on AND
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            stat <= `LBS_STAT_RST;
        else if (act && dif.op == lbs_pkg::LBS_AND)
            stat[`LBS_ZERO_BIT] <= (and_res == 8'h00);
    end

    // byte write-back path
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            BYTE_WE_OUT <= 1'b0;
            BYTE_WDATA_OUT <= 8'h00;
        end
        else if (CLK_EN_IN)
        begin
            BYTE_WE_OUT <= 1'b0;
            if (act && dif.op == lbs_pkg::LBS_AND && dif.dest)
            begin
                BYTE_WE_OUT <= 1'b1;
                BYTE_WDATA_OUT <= and_res;
            end
            else if (act && dif.op == lbs_pkg::LBS_BCLR)
            begin
                BYTE_WE_OUT <= 1'b1;
                BYTE_WDATA_OUT <= BYTE_IN & ~(8'h01 << dif.bidx);
            end
        end
    end

    // skip decision: equal when diff zero, greater when no borrow and diff nonzero
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            skip_pend <= 1'b0;
        else if (CLK_EN_IN && INSTR_VALID_IN)
        begin
            if (skip_pend)
                skip_pend <= 1'b0; // forced nop consumed
            else if (dif.op == lbs_pkg::LBS_CSEQ)
                skip_pend <= (diff == 9'h000);
            else if (dif.op == lbs_pkg::LBS_CSGT)
                skip_pend <= !diff[8] && (diff[7:0] != 8'h00);
            else
                skip_pend <= 1'b0;
        end
    end

    // forced nop marker for the slot being discarded
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            NOP_EXEC_OUT <= 1'b0;
        else if (CLK_EN_IN)
            NOP_EXEC_OUT <= INSTR_VALID_IN && skip_pend;
    end

    assign ACC_OUT = acc;
    assign STATUS_OUT = stat;
    assign SKIP_OUT = skip_pend;

    // checks: each looks at the registered result one cycle on; the and, bit clear
    // and compare checks rebuild it from operands taken by $past, so a wrong operand mux
    // in the datapath trips here and not only in the bench model

    // destination bit low: and result lands in the accumulator
    chk_and_acc_dest: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        act && dif.op == lbs_pkg::LBS_AND && !dif.dest
        |=> ACC_OUT == ($past(acc) & $past(BYTE_IN)))
        else $error("and result not in acc");

    // destination bit high: and result leaves on the byte write port
    chk_and_byte_dest: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        act && dif.op == lbs_pkg::LBS_AND && dif.dest
        |=> BYTE_WE_OUT
        && BYTE_WDATA_OUT == ($past(acc) & $past(BYTE_IN)))
        else $error("and result not written to byte");

    // zero flag follows the full 8-bit and result
    chk_zero_flag: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        act && dif.op == lbs_pkg::LBS_AND
        |=> STATUS_OUT[`LBS_ZERO_BIT]
        == (($past(acc) & $past(BYTE_IN)) == 8'h00))
        else $error("zero flag wrong after and");

    // upper status bits never move
    chk_other_flags: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        1'b1 |=> STATUS_OUT[7:1] == $past(stat[7:1]))
        else $error("non-zero flag changed");

    // only an executed and may touch status; bit clear, compares and
    // discarded slots must leave it exactly as it was
    chk_stat_hold: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        !(act && dif.op == lbs_pkg::LBS_AND)
        |=> STATUS_OUT == $past(stat))
        else $error("status moved without an and");

    // bit clear: chosen bit low, the other seven exactly as read
    chk_bit_clear: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        act && dif.op == lbs_pkg::LBS_BCLR
        |=> BYTE_WE_OUT
        && BYTE_WDATA_OUT[$past(dif.bidx)] == 1'b0
        && (BYTE_WDATA_OUT | (8'h01 << $past(dif.bidx)))
        == ($past(BYTE_IN) | (8'h01 << $past(dif.bidx)))
        && STATUS_OUT == $past(stat))
        else $error("bit clear wrong");

    // equal compare arms the skip
    chk_skip_equal: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        act && dif.op == lbs_pkg::LBS_CSEQ
        |=> SKIP_OUT == ($past(BYTE_IN) == $past(acc)))
        else $error("equal skip wrong");

    // greater compare is unsigned, byte above acc
    chk_skip_greater: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        act && dif.op == lbs_pkg::LBS_CSGT
        |=> SKIP_OUT == ($past(BYTE_IN) > $past(acc)))
        else $error("greater skip wrong");

    // an armed skip eats exactly the next valid slot as a nop
    chk_skip_consume: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        CLK_EN_IN && INSTR_VALID_IN && SKIP_OUT
        |=> !SKIP_OUT && NOP_EXEC_OUT && !BYTE_WE_OUT
        && STATUS_OUT == $past(stat))
        else $error("skipped slot not discarded");

    // compares touch neither operand nor any flag
    chk_cmp_no_effect: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        act && (dif.op == lbs_pkg::LBS_CSEQ
        || dif.op == lbs_pkg::LBS_CSGT) && !ACC_LOAD_IN
        |=> !BYTE_WE_OUT && ACC_OUT == $past(acc)
        && STATUS_OUT == $past(stat))
        else $error("compare modified state");

    // low enable freezes acc, skip, byte write enable and nop marker, pulses included
    chk_enable_freeze: assert property (@(posedge SYS_CLK_IN)
        disable iff (RST_IN)
        !CLK_EN_IN
        |=> ACC_OUT == $past(acc) && SKIP_OUT == $past(skip_pend)
        && BYTE_WE_OUT == $past(BYTE_WE_OUT)
        && NOP_EXEC_OUT == $past(NOP_EXEC_OUT))
        else $error("state moved with enable low");

    // scenarios every run should reach
    cov_and: cover property (@(posedge SYS_CLK_IN)
        act && dif.op == lbs_pkg::LBS_AND);
    cov_and_byte: cover property (@(posedge SYS_CLK_IN)
        act && dif.op == lbs_pkg::LBS_AND && dif.dest);
    cov_bclr: cover property (@(posedge SYS_CLK_IN)
        act && dif.op == lbs_pkg::LBS_BCLR);
    cov_greater_skip: cover property (@(posedge SYS_CLK_IN)
        act && dif.op == lbs_pkg::LBS_CSGT && BYTE_IN > acc);
    cov_skip_nop: cover property (@(posedge SYS_CLK_IN)
        SKIP_OUT && CLK_EN_IN && INSTR_VALID_IN ##1 NOP_EXEC_OUT);
endmodule // lbs_exec
`default_nettype wire

// ### core/lbs_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lbs_if;
    logic [15:0] instr;
    lbs_pkg::lbs_op_t op;
    logic dest;
    logic [2:0] bidx;
    modport dec (input instr, output op, dest, bidx);
    modport use_side (output instr, input op, dest, bidx);
endinterface
`default_nettype wire

// ### core/lbs_params.svh
`ifndef LBS_PARAMS_SVH
`define LBS_PARAMS_SVH
// opcode patterns and field bits, zero flag bit, reset values
`define LBS_OP_AND_HI 7'h05
`define LBS_OP_AND_HI_MSB 15
`define LBS_OP_AND_HI_LSB 9
`define LBS_OP_DEST_BIT 8
`define LBS_OP_BCLR_HI 5'h11
`define LBS_OP_BCLR_HI_MSB 15
`define LBS_OP_BCLR_HI_LSB 11
`define LBS_OP_BIDX_MSB 10
`define LBS_OP_BIDX_LSB 8
`define LBS_OP_CSEQ 8'h31
`define LBS_OP_CSGT 8'h32
`define LBS_ZERO_BIT 0
`define LBS_ACC_RST 8'h00
`define LBS_STAT_RST 8'h00
`endif

// ### core/lbs_pkg.sv
`default_nettype none
package lbs_pkg;
    typedef enum logic [2:0]
    {
        LBS_NONE = 3'b000,
        LBS_AND = 3'b001,
        LBS_BCLR = 3'b010,
        LBS_CSEQ = 3'b011,
        LBS_CSGT = 3'b100
    } lbs_op_t;
endpackage
`default_nettype wire

// ### tb/test_logic_bit_compare_skip_ops.sv
`timescale 1ns/1ns
`default_nettype none
module test_logic_bit_compare_skip_ops;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic vld = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [7:0] byt = 8'h00;
    logic ld = 1'b0;
    logic [7:0] ld_d = 8'h00;
    logic [7:0] acc, stat, wd;
    logic we, skip, nop;
    logic [31:0] seed = 32'h90F0E2FE;
    int n_fail = 0;
    int num_checks = 0;
    int m_acc, m_stat, m_wd, m_we, m_skip, m_nop, a0, r;
    lbs_exec i_lbs_exec (.SYS_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(en),
        .INSTR_VALID_IN(vld), .INSTR_IN(instr), .BYTE_IN(byt),
        .ACC_LOAD_IN(ld), .ACC_LOAD_DATA_IN(ld_d), .ACC_OUT(acc),
        .STATUS_OUT(stat), .BYTE_WE_OUT(we), .BYTE_WDATA_OUT(wd),
        .SKIP_OUT(skip), .NOP_EXEC_OUT(nop));
    // 50 ns period
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk_val(input string nm, input int e, input logic [7:0] s);
        num_checks++;
        if (s !== e[7:0])
        begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", nm, e[7:0], s);
        end
    endtask
    task automatic chk_flag(input string nm, input int e, input logic s);
        num_checks++;
        if (s !== e[0])
        begin
            n_fail++;
            $display("[ERR] %s exp %b seen %b", nm, e[0], s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // reference model, old acc feeds both and and compares
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            {m_acc, m_stat, m_wd, m_we, m_skip, m_nop} = '0;
        else if (en)
        begin
            a0 = m_acc;
            m_we = 0;
            m_nop = 0;
            if (ld)
                m_acc = ld_d;
            if (vld && m_skip)
            begin
                m_skip = 0;
                m_nop = 1;
            end
            else if (vld && instr[15:9] == 7'h05)
            begin
                r = a0 & byt;
                m_stat = (r == 0);
                if (instr[8])
                begin
                    m_we = 1;
                    m_wd = r;
                end
                else
                    m_acc = r;
            end
            else if (vld && instr[15:11] == 5'h11)
            begin
                m_we = 1;
                m_wd = byt & ~(1 << instr[10:8]);
            end
            else if (vld && instr[15:8] == 8'h31)
                m_skip = (byt == a0);
            else if (vld && instr[15:8] == 8'h32)
                m_skip = (byt > a0);
        end
    end
    // compare at the falling edge, then drive the next cycle
    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 4000; i++)
        begin
            @(negedge clk);
            chk_val("acc", m_acc, acc);
            chk_val("status", m_stat, stat);
            chk_flag("byte_we", m_we, we);
            if (m_we != 0)
                chk_val("byte_wdata", m_wd, wd);
            chk_flag("skip", m_skip, skip);
            chk_flag("nop_exec", m_nop, nop);
            seed = xs(seed);
            case (seed[1:0])
                2'h0: instr = {7'h05, seed[8], seed[23:16]};
                2'h1: instr = {5'h11, seed[10:8], seed[23:16]};
                2'h2: instr = {8'h31, seed[23:16]};
                default: instr = {8'h32, seed[23:16]};
            endcase
            if (seed[15:12] == 4'h0)
                instr = seed[31:16];
            byt = seed[21] ? seed[31:24] : m_acc[7:0] + {7'h00, seed[2]};
            vld = seed[22] | seed[23];
            en = seed[26:24] != 3'h0;
            ld = seed[27] & seed[28] & seed[29];
            ld_d = seed[11] ? 8'h00 : seed[15:8];
            // short async reset in mid-run; model clears on the same edge
            rst = (i >= 2000 && i < 2003);
        end
        finish_test();
    end
endmodule // test_logic_bit_compare_skip_ops
`default_nettype wire
